// ==== design/i2cs_slave_link.sv ====
// Our own choices: the register addresses and the AXI4-Lite slave port.
`include "i2cs_defs.svh"

// Function
// - as receiver, drive ack_out_bit on the 9th clock; 0 acknowledges
// - the 8th bit after START is captured into master_read_request
// - master_read_request reads 1 for a master read, 0 for a write
// - with match_wake_enable set, an address match wakes the device
// - as transmitter, sample master ack on 9th clock into ack_in_flag
// - keep sending while ack_in_flag is 0; on 1 release the data line
// - START is data falling while clock high; it sets bus_busy_flag
// - after START take seven address bits msb first, compare with own address
// - address match sets addr_match_flag and raises the interrupt request
// - after a match hold the clock until data write or dummy read
// - a matching calling address is acknowledged on the bus
// - the slave never generates a START condition
// - byte_done_flag low while moving, high with interrupt at byte end
// - bus_busy_flag clears when a STOP is detected
// - enable rising resets status flags, keeps transmit_select and ack_out_bit
// - data bytes are eight bits, msb first, after the address ack
module i2cs_slave_link
  import i2cs_pkg::*;
#(
  parameter int TO_UNIT_CYC = `I2CS_TO_UNIT_CYC // clocks per time-out step
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [7:0] s_axi_awaddr, // write byte address
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  output logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  input wire logic [7:0] s_axi_araddr, // read byte address
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  input wire logic scl_i, // clock line level
  output logic scl_o, // clock line drive value
  output logic scl_oe_b, // clock line drive, low drives
  input wire logic sda_i, // data line level
  output logic sda_o, // data line drive value
  output logic sda_oe_b, // data line drive, low drives
  input wire logic low_power, // cpu is in sleep or idle
  output logic irq_req, // interrupt request pulse
  output logic wake_req // wake-up request pulse
);

  i2cs_state_t state_reg;
  i2cs_stat_t st_reg;
  logic en_reg;
  logic en_d_reg;
  logic irq_en_reg;
  logic [6:0] own_reg;
  logic [7:0] data_reg;
  logic [7:0] sh_reg;
  logic [3:0] cnt_reg;
  logic toen_reg;
  logic tof_reg;
  logic [5:0] tos_reg;
  logic [23:0] to_cnt_reg;
  logic ev_match_reg;
  logic ev_done_reg;
  logic [7:0] wa_reg;
  logic [31:0] wd_reg;
  logic [3:0] ws_reg;
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;

  // ---- pin sampling ----
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
    end else begin
      scl_s1_reg <= scl_i;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= sda_i;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s2_reg & ~scl_s3_reg;
  assign scl_fall = ~scl_s2_reg & scl_s3_reg;
  assign bus_start = scl_s2_reg & scl_s3_reg & ~sda_s2_reg & sda_s3_reg;
  assign bus_stop = scl_s2_reg & scl_s3_reg & sda_s2_reg & ~sda_s3_reg;

  // ---- bus slave ----
  logic wr_go, rd_go, wr_hit, rd_hit;
  logic [7:0] rd_val;
  assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;

  function automatic logic wr_sel(input logic [7:0] ofs);
    wr_sel = wr_go && wa_reg == ofs && ws_reg[0];
  endfunction

  logic data_wr, data_rd;
  assign data_wr = wr_sel(`I2CS_OFS_DATA);
  assign data_rd = rd_go && s_axi_araddr == `I2CS_OFS_DATA;

  always_comb begin
    wr_hit = 1'b1;
    case (wa_reg)
      `I2CS_OFS_CTRL, `I2CS_OFS_STAT, `I2CS_OFS_ADDR,
      `I2CS_OFS_DATA, `I2CS_OFS_TOC, `I2CS_OFS_IRQEN: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `I2CS_OFS_CTRL: rd_val = {6'h00, en_reg, 1'b0};
      `I2CS_OFS_STAT: rd_val = st_reg;
      `I2CS_OFS_ADDR: rd_val = {own_reg, 1'b0};
      `I2CS_OFS_DATA: rd_val = data_reg;
      `I2CS_OFS_TOC: rd_val = {toen_reg, tof_reg, tos_reg};
      `I2CS_OFS_IRQEN: rd_val = {7'h00, irq_en_reg};
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // write channels are taken in either order, then answered together
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `I2CS_RESP_OKAY;
      wa_reg <= 8'h00;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wa_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `I2CS_RESP_OKAY : `I2CS_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `I2CS_RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_val};
        s_axi_rresp <= rd_hit ? `I2CS_RESP_OKAY : `I2CS_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---- plain configuration ----
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      en_reg <= 1'b0;
      en_d_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      own_reg <= `I2CS_OWN_RST;
    end else begin
      en_d_reg <= en_reg;
      if (wr_sel(`I2CS_OFS_CTRL)) en_reg <= wd_reg[`I2CS_CTRL_EN];
      if (wr_sel(`I2CS_OFS_IRQEN)) irq_en_reg <= wd_reg[`I2CS_IRQEN_BIT];
      if (wr_sel(`I2CS_OFS_ADDR)) own_reg <= wd_reg[7:1];
    end
  end

  // ---- time-out ----
  logic to_run, to_fire;
  logic [23:0] to_lim;
  assign to_run = toen_reg && en_reg && state_reg != S_IDLE
                  && state_reg != S_ADDR && state_reg != S_WAIT;
  assign to_lim = 24'((32'(tos_reg) + 32'd1) * 32'(TO_UNIT_CYC));
  assign to_fire = to_run && to_cnt_reg == to_lim - 24'd1;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      to_cnt_reg <= 24'h000000;
    end else if (!to_run || scl_fall || to_fire) begin
      to_cnt_reg <= 24'h000000;
    end else begin
      to_cnt_reg <= to_cnt_reg + 24'd1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {toen_reg, tof_reg, tos_reg} <= `I2CS_TOC_RST;
    end else begin
      if (wr_sel(`I2CS_OFS_TOC)) begin
        toen_reg <= wd_reg[`I2CS_TOC_EN];
        tof_reg <= wd_reg[`I2CS_TOC_FLAG];
        tos_reg <= wd_reg[5:0];
      end
      // a time-out in the clearing cycle still shows
      if (to_fire) begin
        toen_reg <= 1'b0;
        tof_reg <= 1'b1;
      end
    end
  end

  // ---- protocol engine ----
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= S_IDLE;
      st_reg <= `I2CS_STAT_RST;
      data_reg <= 8'h00;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      sda_oe_b <= 1'b1;
      scl_oe_b <= 1'b1;
      ev_match_reg <= 1'b0;
      ev_done_reg <= 1'b0;
    end else begin
      ev_match_reg <= 1'b0;
      ev_done_reg <= 1'b0;
      if (data_wr) data_reg <= wd_reg[7:0];
      if (wr_sel(`I2CS_OFS_STAT)) begin
        st_reg.transmit_select <= wd_reg[4];
        st_reg.ack_out_bit <= wd_reg[3];
        st_reg.match_wake_enable <= wd_reg[1];
      end
      if (!en_reg || to_fire) begin
        state_reg <= S_IDLE;
        sda_oe_b <= 1'b1;
        scl_oe_b <= 1'b1;
        if (to_fire) st_reg <= `I2CS_STAT_RST;
      end else if (!en_d_reg) begin
        st_reg.byte_done_flag <= 1'b1;
        st_reg.addr_match_flag <= 1'b0;
        st_reg.bus_busy_flag <= 1'b0;
        st_reg.master_read_request <= 1'b0;
        st_reg.ack_in_flag <= 1'b1;
      end else if (bus_start) begin
        // only ever detected, never driven: lines change only while clock low
        st_reg.bus_busy_flag <= 1'b1;
        st_reg.addr_match_flag <= 1'b0;
        state_reg <= S_ADDR;
        cnt_reg <= 4'h0;
        sda_oe_b <= 1'b1;
        scl_oe_b <= 1'b1;
      end else if (bus_stop) begin
        st_reg.bus_busy_flag <= 1'b0;
        state_reg <= S_IDLE;
        sda_oe_b <= 1'b1;
        scl_oe_b <= 1'b1;
      end else begin
        case (state_reg)
          S_ADDR: begin
            if (scl_rise) begin
              sh_reg <= {sh_reg[6:0], sda_s2_reg};
              cnt_reg <= cnt_reg + 4'd1;
            end else if (scl_fall && cnt_reg == 4'd8) begin
              if (sh_reg[7:1] == own_reg) begin
                st_reg.addr_match_flag <= 1'b1;
                st_reg.master_read_request <= sh_reg[0];
                ev_match_reg <= 1'b1;
                sda_oe_b <= 1'b0;
                state_reg <= S_AACK;
              end else begin
                state_reg <= S_WAIT;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              sda_oe_b <= 1'b1;
              scl_oe_b <= 1'b0;
              state_reg <= S_HOLD;
            end
          end
          S_HOLD: begin
            // transmit_select picks the direction; the matching data access frees the clock
            if (st_reg.transmit_select && data_wr) begin
              sh_reg <= wd_reg[7:0];
              sda_oe_b <= wd_reg[7];
              cnt_reg <= 4'h0;
              st_reg.byte_done_flag <= 1'b0;
              scl_oe_b <= 1'b1;
              state_reg <= S_TX;
            end else if (!st_reg.transmit_select && data_rd) begin
              cnt_reg <= 4'h0;
              st_reg.byte_done_flag <= 1'b0;
              scl_oe_b <= 1'b1;
              state_reg <= S_RX;
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (cnt_reg == 4'd7) begin
                sda_oe_b <= 1'b1;
                state_reg <= S_TACK;
              end else begin
                sh_reg <= {sh_reg[6:0], 1'b0};
                sda_oe_b <= sh_reg[6];
                cnt_reg <= cnt_reg + 4'd1;
              end
            end
          end
          S_TACK: begin
            if (scl_rise) begin
              st_reg.ack_in_flag <= sda_s2_reg;
            end else if (scl_fall) begin
              st_reg.byte_done_flag <= 1'b1;
              ev_done_reg <= 1'b1;
              if (!st_reg.ack_in_flag) begin
                scl_oe_b <= 1'b0;
                state_reg <= S_HOLD;
              end else begin
                state_reg <= S_WAIT;
              end
            end
          end
          S_RX: begin
            if (scl_rise) begin
              sh_reg <= {sh_reg[6:0], sda_s2_reg};
              cnt_reg <= cnt_reg + 4'd1;
            end else if (scl_fall && cnt_reg == 4'd8) begin
              data_reg <= sh_reg;
              sda_oe_b <= st_reg.ack_out_bit;
              st_reg.byte_done_flag <= 1'b1;
              ev_done_reg <= 1'b1;
              state_reg <= S_RACK;
            end
          end
          S_RACK: begin
            if (scl_fall) begin
              sda_oe_b <= 1'b1;
              scl_oe_b <= 1'b0;
              state_reg <= S_HOLD;
            end
          end
          S_IDLE, S_WAIT: begin
            sda_oe_b <= 1'b1;
            scl_oe_b <= 1'b1;
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // ---- requests to the cpu ----
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_req <= 1'b0;
      wake_req <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      irq_req <= irq_en_reg & (ev_match_reg | ev_done_reg | to_fire);
      wake_req <= ev_match_reg & st_reg.match_wake_enable & low_power;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

endmodule

// ==== design/i2cs_defs.svh ====
`ifndef I2CS_DEFS_SVH
`define I2CS_DEFS_SVH

// register byte offsets
`define I2CS_OFS_CTRL 8'h00
`define I2CS_OFS_STAT 8'h04
`define I2CS_OFS_ADDR 8'h08
`define I2CS_OFS_DATA 8'h0c
`define I2CS_OFS_TOC 8'h10
`define I2CS_OFS_IRQEN 8'h14

// field positions
`define I2CS_CTRL_EN 1
`define I2CS_IRQEN_BIT 0
`define I2CS_TOC_EN 7
`define I2CS_TOC_FLAG 6

// reset values
`define I2CS_STAT_RST 8'h81
`define I2CS_OWN_RST 7'h00
`define I2CS_TOC_RST 8'h00

// time-out step: one slow-clock unit of 32 ticks, in system clocks
`define I2CS_TO_UNIT_CYC 200000

// bus answers
`define I2CS_RESP_OKAY 2'h0
`define I2CS_RESP_SLVERR 2'h2

`endif

// ==== design/i2cs_pkg.sv ====
package i2cs_pkg;

  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_AACK,
    S_HOLD,
    S_TX,
    S_TACK,
    S_RX,
    S_RACK,
    S_WAIT
  } i2cs_state_t;

  // status/control byte, msb first
  typedef struct packed {
    logic byte_done_flag;
    logic addr_match_flag;
    logic bus_busy_flag;
    logic transmit_select;
    logic ack_out_bit;
    logic master_read_request;
    logic match_wake_enable;
    logic ack_in_flag;
  } i2cs_stat_t;

endpackage

// ==== test/i2cs_link_sva.sv ====
module i2cs_link_sva
  import i2cs_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic s_axi_rvalid, // read data valid
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic scl_i, // clock line level
  input wire logic scl_oe_b, // clock line drive
  input wire logic sda_oe_b, // data line drive
  input wire logic low_power, // cpu asleep
  input wire logic irq_req, // interrupt pulse
  input wire logic wake_req // wake pulse
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // the synchroniser delay keeps every data change well inside the low phase
  AST_SDA_MOVES: assert property (
    $changed(sda_oe_b) |-> !scl_i && !$past(scl_i))
    else $error("data drive changed near a high clock");
  AST_SDA_HOLD: assert property (
    $rose(scl_i) |=> $stable(sda_oe_b) [*4])
    else $error("data drive moved during clock high");
  AST_STRETCH_START: assert property (
    $fell(scl_oe_b) |-> !scl_i && !$past(scl_i))
    else $error("stretch began with clock high");
  AST_STRETCH_END: assert property (
    $rose(scl_oe_b) |-> $rose(s_axi_bvalid) || $past(s_axi_arvalid && s_axi_arready))
    else $error("stretch ended without software access");
  AST_IRQ_ON_FALL: assert property (
    irq_req |-> !scl_i && !$past(scl_i))
    else $error("interrupt not at a clock fall");
  AST_IRQ_PULSE: assert property (
    irq_req |=> !irq_req)
    else $error("interrupt longer than one cycle");
  AST_WAKE: assert property (
    wake_req |-> low_power && !scl_i)
    else $error("wake without low power");
  AST_B_ANSWER: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  AST_R_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or wide");
endmodule

bind i2cs_slave_link i2cs_link_sva chk (.*);

// ==== test/i2cs_bus_master_model.sv ====
module i2cs_bus_master_model
  import i2cs_pkg::*;
(
  input wire logic scl, // clock line level
  input wire logic sda, // data line level
  output logic scl_low, // pulls clock low
  output logic sda_low // pulls data low
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic q();
    #16;
  endtask
  task automatic start();
    sda_low <= 1'b1;
    q();
    scl_low <= 1'b1;
    q();
  endtask
  // waits out a stretch, as a real master must
  task automatic rise();
    scl_low <= 1'b0;
    q();
    while (!scl) #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    q();
    rise();
    r = sda;
    q();
    scl_low <= 1'b1;
    q();
  endtask
  task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] r,
                         output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(mack, a);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    q();
    rise();
    q();
    sda_low <= 1'b0;
    q();
  endtask
endmodule

// ==== test/i2c_slave_interface_test.sv ====
`include "i2cs_defs.svh"
module i2c_slave_interface_test
  import i2cs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, low_power = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rb;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic scl_o, scl_oe_b, sda_o, sda_oe_b, irq_req, wake_req, m_scl, m_sda, ack;
  wire scl_i = !(scl_oe_b == 1'b0 || m_scl);
  wire sda_i = !(sda_oe_b == 1'b0 || m_sda);
  int n_errors = 0, cmp_count = 0, cyc = 0, n_irq = 0, n_wake = 0;

  i2cs_slave_link #(.TO_UNIT_CYC(20)) dut (.*);
  i2cs_bus_master_model m (.scl(scl_i), .sda(sda_i), .scl_low(m_scl), .sda_low(m_sda));

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (irq_req === 1'b1) n_irq++;
    if (wake_req === 1'b1) n_wake++;
    if (cyc == 30000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic pa, pw;
    @(posedge clk_sys);
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge clk_sys);
      if (pa && s_axi_awready) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge clk_sys);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic stat(input logic [7:0] mask, input logic [7:0] exp);
    rd(`I2CS_OFS_STAT);
    chk(rv & {24'h0, mask}, {24'h0, exp}, "status");
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    stat(8'hff, `I2CS_STAT_RST);
    rd(`I2CS_OFS_ADDR);
    chk(rv, 32'h0, "own address");
    rd(8'h18);
    chk(32'(rr), 32'h2, "unmapped response");
    wr(`I2CS_OFS_CTRL, 8'h02);
    wr(`I2CS_OFS_ADDR, 8'h54);
    wr(`I2CS_OFS_IRQEN, 8'h01);
    wr(`I2CS_OFS_STAT, 8'h02);
    // master write: two bytes, the second refused by ack_out_bit
    m.start();
    m.byte_io(8'h54, 1'b1, rb, ack);
    chk(32'(ack), 32'h0, "address ack");
    stat(8'h64, 8'h60);
    chk(32'(scl_oe_b), 32'h0, "stretch");
    rd(`I2CS_OFS_DATA);
    m.byte_io(8'ha5, 1'b1, rb, ack);
    chk(32'(ack), 32'h0, "data ack");
    stat(8'h80, 8'h80);
    rd(`I2CS_OFS_DATA);
    chk(rv, 32'ha5, "rx byte");
    wr(`I2CS_OFS_STAT, 8'h08);
    m.byte_io(8'h3c, 1'b1, rb, ack);
    chk(32'(ack), 32'h1, "data nack");
    rd(`I2CS_OFS_DATA);
    chk(rv, 32'h3c, "rx byte");
    wr(`I2CS_OFS_STAT, 8'h00);
    m.stop();
    stat(8'h20, 8'h00);
    // master read: acked byte, then a refused one
    m.start();
    m.byte_io(8'h55, 1'b1, rb, ack);
    chk(32'(ack), 32'h0, "address ack");
    stat(8'h64, 8'h64);
    wr(`I2CS_OFS_STAT, 8'h10);
    chk(32'(scl_oe_b), 32'h0, "stretch");
    wr(`I2CS_OFS_DATA, 8'hc3);
    m.byte_io(8'hff, 1'b0, rb, ack);
    chk(32'(rb), 32'hc3, "tx byte");
    stat(8'h81, 8'h80);
    wr(`I2CS_OFS_DATA, 8'h5a);
    m.byte_io(8'hff, 1'b1, rb, ack);
    chk(32'(rb), 32'h5a, "tx byte");
    stat(8'h01, 8'h01);
    chk(32'(sda_oe_b), 32'h1, "data released");
    m.stop();
    // foreign address is ignored
    m.start();
    m.byte_io(8'h20, 1'b1, rb, ack);
    chk(32'(ack), 32'h1, "foreign address");
    m.stop();
    wr(`I2CS_OFS_CTRL, 8'h00);
    wr(`I2CS_OFS_CTRL, 8'h02);
    stat(8'hff, 8'h91);
    wr(8'h18, 8'h00);
    chk(32'(rr), 32'h2, "unmapped write response");
    wr(`I2CS_OFS_TOC, 8'h45);
    rd(`I2CS_OFS_TOC);
    chk(rv, 32'h45, "time-out control");
    chk(32'({scl_o, sda_o}), 32'h0, "drive values");
    chk(32'(n_irq), 32'h6, "interrupts");
    chk(32'(n_wake), 32'h1, "wake-ups");
    stop_test();
  end
endmodule
